// ### design/rtc_regs.svh
// timing counts and reset values for the calendar clock
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// ref_clk figures
`define REF_CLK_PERIOD_NS      40
// low-speed oscillator edges per fine wakeup step (61 us), minus one
`define FINE_STEP_LAST         1'h1
// low-speed oscillator edges per second, minus one
`define SECOND_LAST            15'h7FFF

// wakeup tick selections
`define WAKE_SEL_FINE          2'h0
`define WAKE_SEL_SECOND        2'h1
`define WAKE_SEL_SECOND_LONG   2'h2

// calendar limits, BCD
`define SEC_LAST               8'h59
`define MIN_LAST               8'h59
`define HOUR24_LAST            8'h23
`define HOUR12_TOP             8'h12
`define HOUR12_PM_TURN         8'h11
`define WEEKDAY_FIRST          8'h01
`define WEEKDAY_LAST           8'h07
`define DATE_FIRST             8'h01
`define MONTH_FIRST            8'h01
`define MONTH_LAST             8'h12
`define YEAR_LAST              8'h99
`define FEBRUARY               8'h02

// reset values of the calendar, BCD
`define RST_YEAR               8'h00
`define RST_MONTH              5'h01
`define RST_DATE               6'h01
`define RST_WEEKDAY            3'h1
`define RST_HOUR               6'h00

`endif

// ### design/rtc_pkg.sv
// types shared by the calendar clock
`default_nettype none
package rtc_pkg;

   // current or alarm calendar, all fields BCD
   typedef struct packed {
      logic [7:0] year;
      logic [4:0] month;
      logic [5:0] date;
      logic [2:0] weekday;
      logic       pm;
      logic [5:0] hour;
      logic [6:0] minute;
      logic [6:0] second;
   } calendar_t;

   // set bit excludes the field from the alarm compare
   typedef struct packed {
      logic year;
      logic month;
      logic date;
      logic weekday;
      logic hour;
      logic minute;
      logic second;
   } alarm_mask_t;

   typedef enum logic [1:0] {
      WAKE_IDLE,
      WAKE_RUN
   } wake_state_t;

endpackage

`default_nettype wire

// ### design/rtc_tick_gen.sv
// low-speed oscillator synchroniser and tick dividers
`timescale 1ns/10ps
`default_nettype none
`include "rtc_regs.svh"

module rtc_tick_gen (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic low_speed_external_osc,
   output logic      fine_tick,
   output logic      second_tick
);

   logic        osc_meta_reg;
   logic        osc_sync_reg;
   logic        osc_last_reg;
   logic        fine_cnt_reg;
   logic [14:0] sec_cnt_reg;
   logic        osc_rise;

   // ***********************************
   // two-flop synchroniser
   // ***********************************
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         osc_meta_reg <= 1'b0;
         osc_sync_reg <= 1'b0;
         osc_last_reg <= 1'b0;
      end else begin
         osc_meta_reg <= low_speed_external_osc;
         osc_sync_reg <= osc_meta_reg;
         osc_last_reg <= osc_sync_reg;
      end
   end

   assign osc_rise = osc_sync_reg & ~osc_last_reg;

   // ***********************************
   // dividers
   // ***********************************
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         fine_cnt_reg <= 1'b0;
         sec_cnt_reg  <= 15'h0000;
         fine_tick    <= 1'b0;
         second_tick  <= 1'b0;
      end else begin
         fine_tick   <= osc_rise && (fine_cnt_reg == `FINE_STEP_LAST);
         second_tick <= osc_rise && (sec_cnt_reg == `SECOND_LAST);
         if (osc_rise) begin
            fine_cnt_reg <= fine_cnt_reg + 1'b1;
            sec_cnt_reg  <= sec_cnt_reg + 15'h0001;
         end
      end
   end

endmodule // rtc_tick_gen

`default_nettype wire

// ### design/rtc_calendar.sv
// BCD calendar clock with alarm and periodic wakeup
`timescale 1ns/10ps
`default_nettype none
`include "rtc_regs.svh"

// Behaviour
// - keep seconds to year as BCD in the calendar fields.
// - hours count in 12-hour form with pm bit, or 24-hour form.
// - month end follows month length, February 29 days in leap years.
// - alarm and periodic wakeup both raise the wake request.
// - fine wakeup steps of 61 us give 61 us to about 4 s.
// - one-second wakeup steps with a long range reach 36 hours.
// - masking fields gives alarms repeating each second up to each year.
module rtc_calendar (
   input  wire logic                  ref_clk,
   input  wire logic                  nrst,
   input  wire logic                  low_speed_external_osc,
   input  wire logic                  hour_12_mode,
   input  wire logic                  set_time,
   input  wire rtc_pkg::calendar_t    set_value,
   input  wire logic                  alarm_enable,
   input  wire rtc_pkg::calendar_t    alarm_value,
   input  wire rtc_pkg::alarm_mask_t  alarm_mask,
   input  wire logic                  alarm_clear,
   input  wire logic                  wakeup_enable,
   input  wire logic [1:0]            wakeup_sel,
   input  wire logic [15:0]           wakeup_reload,
   input  wire logic                  wakeup_clear,
   output rtc_pkg::calendar_t         now_reg,
   output logic                       alarm_flag_reg,
   output logic                       wakeup_flag_reg,
   output logic                       wake_req_reg
);
   import rtc_pkg::*;

   logic         fine_tick;
   logic         second_tick;
   logic         sec_done_reg;
   calendar_t    now_next;
   wake_state_t  wake_state_reg;
   logic [16:0]  wake_cnt_reg;
   logic         wake_tick;
   logic         wake_fire;
   logic         alarm_hit;

   // ***********************************
   // BCD helpers
   // ***********************************
   function automatic logic [7:0] bcd_step(input logic [7:0] v,
                                           input logic [7:0] last,
                                           input logic [7:0] first);
      if (v >= last)
         bcd_step = first;
      else if (v[3:0] == 4'h9)
         bcd_step = {v[7:4] + 4'h1, 4'h0};
      else
         bcd_step = v + 8'h01;
   endfunction

   function automatic logic [7:0] month_last(input logic [7:0] month,
                                             input logic [7:0] year);
      logic leap;
      // year divisible by four: odd tens digit needs units 2 or 6
      leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                     : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
      if (month == `FEBRUARY)
         month_last = leap ? 8'h29 : 8'h28;
      else if (month == 8'h04 || month == 8'h06 || month == 8'h09 || month == 8'h11)
         month_last = 8'h30;
      else
         month_last = 8'h31;
   endfunction

   function automatic logic [16:0] wake_load(input logic [1:0]  sel,
                                             input logic [15:0] reload);
      wake_load = {sel == `WAKE_SEL_SECOND_LONG, reload};
   endfunction

   rtc_tick_gen u_tick (
      .ref_clk                (ref_clk),
      .nrst                   (nrst),
      .low_speed_external_osc (low_speed_external_osc),
      .fine_tick              (fine_tick),
      .second_tick            (second_tick)
   );

   // ***********************************
   // calendar rollover
   // ***********************************
   always_comb begin
      logic [7:0] hr;
      logic       day_carry;
      logic [7:0] dlast;
      hr        = {2'b00, now_reg.hour};
      day_carry = 1'b0;
      dlast     = month_last({3'b000, now_reg.month}, now_reg.year);
      now_next  = now_reg;
      now_next.second = 7'(bcd_step({1'b0, now_reg.second}, `SEC_LAST, 8'h00));
      if (now_reg.second == `SEC_LAST) begin
         now_next.minute = 7'(bcd_step({1'b0, now_reg.minute}, `MIN_LAST, 8'h00));
         if (now_reg.minute == `MIN_LAST) begin
            if (hour_12_mode) begin
               if (hr == `HOUR12_TOP)
                  now_next.hour = 6'h01;
               else
                  now_next.hour = 6'(bcd_step(hr, `HOUR12_TOP, 8'h01));
               // 11 to 12 flips am/pm; 11 pm to 12 am starts a new day
               if (hr == `HOUR12_PM_TURN) begin
                  now_next.pm = ~now_reg.pm;
                  day_carry   = now_reg.pm;
               end
            end else begin
               now_next.hour = 6'(bcd_step(hr, `HOUR24_LAST, 8'h00));
               now_next.pm   = 1'b0;
               day_carry     = (hr == `HOUR24_LAST);
            end
         end
      end
      if (day_carry) begin
         now_next.weekday = 3'(bcd_step({5'h00, now_reg.weekday}, `WEEKDAY_LAST,
                                        `WEEKDAY_FIRST));
         now_next.date    = 6'(bcd_step({2'b00, now_reg.date}, dlast, `DATE_FIRST));
         if ({2'b00, now_reg.date} >= dlast) begin
            now_next.month = 5'(bcd_step({3'b000, now_reg.month}, `MONTH_LAST, `MONTH_FIRST));
            if ({3'b000, now_reg.month} == `MONTH_LAST)
               now_next.year = bcd_step(now_reg.year, `YEAR_LAST, 8'h00);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         now_reg <= '{year: `RST_YEAR, month: `RST_MONTH, date: `RST_DATE,
                      weekday: `RST_WEEKDAY, pm: 1'b0, hour: `RST_HOUR,
                      minute: 7'h00, second: 7'h00};
      end else if (set_time) begin
         now_reg <= set_value;
      end else if (second_tick) begin
         now_reg <= now_next;
      end
   end

   // ***********************************
   // alarm
   // ***********************************
   always_comb begin
      alarm_hit = (alarm_mask.second  || alarm_value.second  == now_reg.second)  &&
                  (alarm_mask.minute  || alarm_value.minute  == now_reg.minute)  &&
                  (alarm_mask.hour    || (alarm_value.hour   == now_reg.hour &&
                                          alarm_value.pm     == now_reg.pm))     &&
                  (alarm_mask.weekday || alarm_value.weekday == now_reg.weekday) &&
                  (alarm_mask.date    || alarm_value.date    == now_reg.date)    &&
                  (alarm_mask.month   || alarm_value.month   == now_reg.month)   &&
                  (alarm_mask.year    || alarm_value.year    == now_reg.year);
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sec_done_reg   <= 1'b0;
         alarm_flag_reg <= 1'b0;
      end else begin
         sec_done_reg <= second_tick && !set_time;
         // compare once per second so masked fields give repeating alarms
         if (sec_done_reg && alarm_enable && alarm_hit)
            alarm_flag_reg <= 1'b1;
         else if (alarm_clear)
            alarm_flag_reg <= 1'b0;
      end
   end

   // ***********************************
   // periodic wakeup
   // ***********************************
   assign wake_tick = (wakeup_sel == `WAKE_SEL_FINE) ? fine_tick : second_tick;
   assign wake_fire = (wake_state_reg == WAKE_RUN) && wake_tick && (wake_cnt_reg == 17'h00000);

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wake_state_reg <= WAKE_IDLE;
         wake_cnt_reg   <= 17'h00000;
      end else begin
         case (wake_state_reg)
            WAKE_IDLE: begin
               if (wakeup_enable) begin
                  wake_state_reg <= WAKE_RUN;
                  wake_cnt_reg   <= wake_load(wakeup_sel, wakeup_reload);
               end
            end
            WAKE_RUN: begin
               // step tick at zero raises the flag and reloads
               if (!wakeup_enable)
                  wake_state_reg <= WAKE_IDLE;
               else if (wake_fire)
                  wake_cnt_reg <= wake_load(wakeup_sel, wakeup_reload);
               else if (wake_tick)
                  wake_cnt_reg <= wake_cnt_reg - 17'h00001;
            end
            default: wake_state_reg <= WAKE_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wakeup_flag_reg <= 1'b0;
      end else if (wake_fire) begin
         wakeup_flag_reg <= 1'b1;
      end else if (wakeup_clear) begin
         wakeup_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst)
         wake_req_reg <= 1'b0;
      else
         wake_req_reg <= alarm_flag_reg || wakeup_flag_reg;
   end

endmodule // rtc_calendar

`default_nettype wire

// ### sim/rtc_calendar_properties.sv
// concurrent checks on the calendar clock ports
`timescale 1ns/10ps
`default_nettype none
module rtc_calendar_checker (
   input wire logic                 ref_clk,
   input wire logic                 nrst,
   input wire logic                 hour_12_mode,
   input wire logic                 set_time,
   input wire rtc_pkg::calendar_t   set_value,
   input wire logic                 alarm_enable,
   input wire rtc_pkg::calendar_t   alarm_value,
   input wire rtc_pkg::alarm_mask_t alarm_mask,
   input wire logic                 alarm_clear,
   input wire logic                 wakeup_clear,
   input wire rtc_pkg::calendar_t   now_reg,
   input wire logic                 alarm_flag_reg,
   input wire logic                 wakeup_flag_reg,
   input wire logic                 wake_req_reg
);
   import rtc_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   property p_load;
      set_time |=> now_reg == $past(set_value);
   endproperty
   a_load: assert property (p_load) else $error("calendar load lost");
   property p_sec_wrap;
      $changed(now_reg) && !$past(set_time) && $past(now_reg.second) == 7'h59
      |-> now_reg.second == 7'h00 && now_reg.minute != $past(now_reg.minute);
   endproperty
   a_sec_wrap: assert property (p_sec_wrap) else $error("second carry wrong");
   property p_hold;
      $changed(now_reg) && !$past(set_time) |=> ($stable(now_reg) || $past(set_time)) [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("calendar moved early");
   property p_hour12;
      hour_12_mode && $changed(now_reg.hour) && !$past(set_time)
      |-> now_reg.hour inside {[6'h01:6'h12]};
   endproperty
   a_hour12: assert property (p_hour12) else $error("hour out of 12h range");
   property p_alarm_set;
      $rose(alarm_flag_reg) |-> $past(alarm_enable)
         && (alarm_mask.second || now_reg.second == alarm_value.second)
         && (alarm_mask.hour || now_reg.hour == alarm_value.hour);
   endproperty
   a_alarm_set: assert property (p_alarm_set) else $error("alarm without match");
   property p_alarm_hold;
      alarm_flag_reg && !alarm_clear |=> alarm_flag_reg;
   endproperty
   a_alarm_hold: assert property (p_alarm_hold) else $error("alarm flag lost");
   property p_wake_hold;
      wakeup_flag_reg && !wakeup_clear |=> wakeup_flag_reg;
   endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("wakeup flag lost");
   property p_req_rise;
      alarm_flag_reg || wakeup_flag_reg |=> wake_req_reg;
   endproperty
   a_req_rise: assert property (p_req_rise) else $error("wake request missing");
   property p_req_fall;
      !alarm_flag_reg && !wakeup_flag_reg |=> !wake_req_reg;
   endproperty
   a_req_fall: assert property (p_req_fall) else $error("wake request stuck");
endmodule // rtc_calendar_checker
bind rtc_calendar rtc_calendar_checker u_chk (.ref_clk(ref_clk), .nrst(nrst),
   .hour_12_mode(hour_12_mode), .set_time(set_time), .set_value(set_value),
   .alarm_enable(alarm_enable), .alarm_value(alarm_value), .alarm_mask(alarm_mask),
   .alarm_clear(alarm_clear), .wakeup_clear(wakeup_clear), .now_reg(now_reg),
   .alarm_flag_reg(alarm_flag_reg), .wakeup_flag_reg(wakeup_flag_reg),
   .wake_req_reg(wake_req_reg));
`default_nettype wire

// ### sim/test_bcd_calendar_rtc_wakeup.sv
// self-checking bench for the calendar clock
`timescale 1ns/10ps
`default_nettype none
`include "rtc_regs.svh"
module test_bcd_calendar_rtc_wakeup;
   import rtc_pkg::*;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        osc_in = 1'b0;
   logic        hour_12_mode = 1'b0;
   logic        set_time = 1'b0;
   calendar_t   set_value = '0;
   logic        alarm_enable = 1'b0;
   calendar_t   alarm_value = '0;
   alarm_mask_t alarm_mask = '1;
   logic        alarm_clear = 1'b0;
   logic        wakeup_enable = 1'b0;
   logic [1:0]  wakeup_sel = 2'h0;
   logic [15:0] wakeup_reload = 16'h0000;
   logic        wakeup_clear = 1'b0;
   calendar_t   now_reg;
   logic        alarm_flag_reg;
   logic        wakeup_flag_reg;
   logic        wake_req_reg;
   int          n_errors = 0;
   int          checks_done = 0;
   calendar_t   rst_cal = '{`RST_YEAR, `RST_MONTH, `RST_DATE, `RST_WEEKDAY, 1'h0, `RST_HOUR,
                            7'h00, 7'h00};
   calendar_t   v1 = '{8'h99, 5'h12, 6'h31, 3'h7, 1'h1, 6'h11, 7'h59, 7'h59};
   calendar_t   exp_cal = '{8'h00, 5'h01, 6'h01, 3'h1, 1'h0, 6'h12, 7'h00, 7'h00};
   rtc_calendar uut (.ref_clk(ref_clk), .nrst(nrst), .low_speed_external_osc(osc_in),
      .hour_12_mode(hour_12_mode), .set_time(set_time), .set_value(set_value),
      .alarm_enable(alarm_enable), .alarm_value(alarm_value), .alarm_mask(alarm_mask),
      .alarm_clear(alarm_clear), .wakeup_enable(wakeup_enable), .wakeup_sel(wakeup_sel),
      .wakeup_reload(wakeup_reload), .wakeup_clear(wakeup_clear), .now_reg(now_reg),
      .alarm_flag_reg(alarm_flag_reg), .wakeup_flag_reg(wakeup_flag_reg),
      .wake_req_reg(wake_req_reg));
   always #(`REF_CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
   // fast stand-in oscillator so a second fits in the run
   always @(negedge ref_clk) osc_in <= ~osc_in;
   // ****************************************
   // compare and closing tasks
   // ****************************************
   task automatic chk_val(input string name, input logic [42:0] e, input logic [42:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic chk_bit(input string name, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %b seen %b", name, e, g);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_load;
      chk_val("reset calendar", rst_cal, now_reg);
      chk_bit("reset wake request", 1'b0, wake_req_reg);
      hour_12_mode = 1'b1;
      set_time = 1'b1;
      set_value = v1;
      @(negedge ref_clk);
      set_time = 1'b0;
      chk_val("loaded calendar", v1, now_reg);
      alarm_value = exp_cal;
      alarm_value.year = 8'h55;
      alarm_mask = 7'h40;
      alarm_enable = 1'b1;
      $display("test load done");
   endtask
   task automatic t_wakeup;
      int n;
      wakeup_reload = 16'h0001;
      wakeup_enable = 1'b1;
      n = 0;
      while (wakeup_flag_reg !== 1'b1 && n < 40) begin
         @(negedge ref_clk);
         n++;
      end
      chk_bit("wakeup first flag", 1'b1, wakeup_flag_reg);
      wakeup_clear = 1'b1;
      @(negedge ref_clk);
      wakeup_clear = 1'b0;
      chk_bit("wakeup request", 1'b1, wake_req_reg);
      n = 1;
      while (wakeup_flag_reg !== 1'b1 && n < 40) begin
         @(negedge ref_clk);
         n++;
      end
      chk_val("wakeup period cycles", 43'h8, 43'(n));
      wakeup_enable = 1'b0;
      wakeup_clear = 1'b1;
      @(negedge ref_clk);
      wakeup_clear = 1'b0;
      repeat (20) @(negedge ref_clk);
      chk_bit("wakeup stopped", 1'b0, wakeup_flag_reg);
      chk_bit("request dropped", 1'b0, wake_req_reg);
      $display("test wakeup done");
   endtask
   task automatic t_rollover;
      int n;
      wakeup_sel = `WAKE_SEL_SECOND_LONG;
      wakeup_reload = 16'h0000;
      wakeup_enable = 1'b1;
      n = 0;
      while (now_reg === v1 && n < 70000) begin
         @(negedge ref_clk);
         n++;
      end
      chk_val("year end rollover", exp_cal, now_reg);
      chk_bit("alarm before compare", 1'b0, alarm_flag_reg);
      repeat (2) @(negedge ref_clk);
      chk_bit("alarm flag", 1'b1, alarm_flag_reg);
      @(negedge ref_clk);
      chk_bit("alarm request", 1'b1, wake_req_reg);
      chk_bit("alarm flag held", 1'b1, alarm_flag_reg);
      alarm_clear = 1'b1;
      @(negedge ref_clk);
      alarm_clear = 1'b0;
      chk_bit("alarm cleared", 1'b0, alarm_flag_reg);
      chk_bit("long wakeup not due", 1'b0, wakeup_flag_reg);
      $display("test rollover done");
   endtask
   initial begin
      repeat (16) @(negedge ref_clk);
      nrst = 1'b1;
      @(negedge ref_clk);
      t_load;
      t_wakeup;
      t_rollover;
      results;
   end
   initial begin
      #(80000 * `REF_CLK_PERIOD_NS);
      n_errors++;
      results;
   end
endmodule // test_bcd_calendar_rtc_wakeup
`default_nettype wire
